/* hw/uftl_front.sv */
// line synchroniser and start, stop and clock edge detection
`timescale 1ns/1ps
`default_nettype none
module uftl_front
    import uftl_pkg::*;
(
    input wire logic clock, // system clock
    input wire logic rst_n, // sync reset, low
    input wire logic scl_pin, // bus clock pin
    input wire logic sda_pin, // bus data pin
    uftl_line_if.front lines // detected events
);
    logic [SYNC_STAGES-1:0] scl_sync_r;
    logic [SYNC_STAGES-1:0] sda_sync_r;
    logic scl_prev_r;
    logic sda_prev_r;
    wire logic scl_now;
    wire logic sda_now;
    assign scl_now = scl_sync_r[SYNC_STAGES-1];
    assign sda_now = sda_sync_r[SYNC_STAGES-1];
    // system clock far faster than bus clock: many samples per period
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            scl_sync_r <= '1;
            sda_sync_r <= '1;
            scl_prev_r <= 1'b1;
            sda_prev_r <= 1'b1;
        end else begin
            scl_sync_r <= {scl_sync_r[SYNC_STAGES-2:0], scl_pin};
            sda_sync_r <= {sda_sync_r[SYNC_STAGES-2:0], sda_pin};
            scl_prev_r <= scl_now;
            sda_prev_r <= sda_now;
        end
    end
    assign lines.clk_rise = scl_now & ~scl_prev_r;
    assign lines.data_bit = sda_now;
    // data moves with clock high only at framing conditions
    assign lines.start_seen = scl_now & scl_prev_r & sda_prev_r & ~sda_now;
    assign lines.stop_seen = scl_now & scl_prev_r & ~sda_prev_r & sda_now;
    chk_start_clock_high: assert property (@(posedge clock) disable iff (!rst_n)
        lines.start_seen |-> scl_now && $past(scl_now))
        else $error("start seen without clock high");
endmodule
`default_nettype wire

/* hw/uftl_slave.sv */
// one-way two-wire slave receiver: framing, addressing, general call
`timescale 1ns/1ps
`default_nettype none
module uftl_slave
    import uftl_pkg::*;
#(
    parameter logic [9:0] OWN_ADDR10 = 10'h2a5, // own ten-bit address
    parameter logic [6:0] OWN_ADDR7_FIXED = 7'h50, // fixed address part
    parameter logic [6:0] PROG_MASK = 7'h03, // programmable address bits
    parameter logic USE_TEN_BIT = 1'b0, // answer ten-bit address
    parameter logic USE_GCALL = 1'b1 // honour general call
)
(
    input wire logic clock, // system clock
    input wire logic rst_n, // sync reset, low
    input wire logic scl_pin, // bus clock line in
    input wire logic sda_pin, // bus data line in
    input wire logic [6:0] prog_addr_pins, // programmable address source
    output logic scl_oe, // clock drive enable, always off
    output logic sda_oe, // data drive enable, always off
    output logic bus_busy, // bus between start and stop
    output logic selected, // addressed by the master
    output logic [7:0] rx_data, // last received data byte
    output logic rx_valid, // one-cycle data byte strobe
    output logic soft_reset, // one-cycle reset pulse
    output logic [6:0] prog_addr // loaded programmable address
);
    import uftl_pkg::*;
    uftl_line_if lines ();
    uftl_front u_front (
        .clock(clock),
        .rst_n(rst_n),
        .scl_pin(scl_pin),
        .sda_pin(sda_pin),
        .lines(lines)
    );
    uftl_state_t state_r, state_nxt;
    logic [3:0] bit_cnt_r;
    logic [7:0] shift_r;
    logic [6:0] pins_s1_r, pins_s2_r;
    logic busy_r, sel_r, valid_r, srst_r;
    logic [7:0] data_r;
    logic [6:0] prog_r;
    wire logic [7:0] byte_full;
    wire logic byte_done;
    wire logic ninth_done;
    wire logic [6:0] own7;
    wire logic is_gcall;
    wire logic is_ten;
    wire logic ten_match1;
    wire logic own7_match;
    wire logic gc_load;
    wire logic gc_reset;
    assign byte_full = {shift_r[6:0], lines.data_bit};
    assign byte_done = lines.clk_rise && bit_cnt_r == BIT_LAST;
    assign ninth_done = lines.clk_rise && bit_cnt_r == BIT_NINTH;
    assign own7 = (OWN_ADDR7_FIXED & ~PROG_MASK) | (prog_r & PROG_MASK);
    assign is_gcall = byte_full == {GCALL_ADDR, 1'b0};
    assign is_ten = byte_full[7:3] == TEN_PREFIX;
    assign ten_match1 = USE_TEN_BIT && is_ten
        && byte_full[2:1] == OWN_ADDR10[9:8] && !byte_full[0];
    // reserved groups never match; read bit only as start byte
    assign own7_match = !USE_TEN_BIT && byte_full[7:1] == own7
        && !byte_full[0] && byte_full[7:4] != RSV_LOW_HI
        && byte_full[7:4] != RSV_HIGH_HI;
    // odd or unassigned codes fall through ignored
    assign gc_load = byte_full == GC_LOAD;
    assign gc_reset = byte_full == GC_RESET_LOAD;
    always_comb begin
        state_nxt = state_r;
        if (lines.start_seen) begin
            state_nxt = UFTL_ADDR;
        end else if (lines.stop_seen) begin
            state_nxt = UFTL_IDLE;
        end else if (byte_done) begin
            case (state_r)
                UFTL_ADDR: begin
                    if (ten_match1) begin
                        state_nxt = UFTL_ADDR2;
                    end else if (own7_match) begin
                        state_nxt = UFTL_DATA;
                    end else if (is_gcall && USE_GCALL) begin
                        state_nxt = UFTL_GCALL;
                    end else begin
                        state_nxt = UFTL_IGNORE;
                    end
                end
                UFTL_ADDR2: begin
                    if (byte_full == OWN_ADDR10[7:0]) begin
                        state_nxt = UFTL_DATA;
                    end else begin
                        state_nxt = UFTL_IGNORE;
                    end
                end
                UFTL_GCALL: state_nxt = UFTL_IGNORE;
                UFTL_DATA: state_nxt = UFTL_DATA;
                UFTL_IGNORE: state_nxt = UFTL_IGNORE;
                default: state_nxt = UFTL_IGNORE;
            endcase
        end
    end
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            state_r <= UFTL_IDLE;
            bit_cnt_r <= 4'h0;
            shift_r <= 8'h00;
        end else begin
            state_r <= state_nxt;
            shift_r <= lines.clk_rise ? byte_full : shift_r;
            if (lines.start_seen || lines.stop_seen || ninth_done) begin
                bit_cnt_r <= 4'h0;
            end else if (lines.clk_rise) begin
                bit_cnt_r <= bit_cnt_r + 4'h1;
            end
        end
    end
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            busy_r <= 1'b0;
            sel_r <= 1'b0;
        end else begin
            busy_r <= lines.start_seen | (busy_r & ~lines.stop_seen);
            sel_r <= state_nxt == UFTL_DATA;
        end
    end
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            valid_r <= 1'b0;
            data_r <= 8'h00;
        end else begin
            valid_r <= byte_done && state_r == UFTL_DATA;
            data_r <= (byte_done && state_r == UFTL_DATA) ? byte_full : data_r;
        end
    end
    wire logic gc_hit;
    assign gc_hit = byte_done && state_r == UFTL_GCALL;
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            pins_s1_r <= 7'h00;
            pins_s2_r <= 7'h00;
            srst_r <= 1'b0;
            prog_r <= 7'h00;
        end else begin
            pins_s1_r <= prog_addr_pins;
            pins_s2_r <= pins_s1_r;
            srst_r <= gc_hit && gc_reset;
            if (gc_hit && (gc_load || gc_reset)) begin
                prog_r <= pins_s2_r;
            end
        end
    end
    // receive only: no drive on either line ever
    always_ff @(posedge clock) begin
        scl_oe <= 1'b0;
        sda_oe <= 1'b0;
    end
    assign bus_busy = busy_r;
    assign selected = sel_r;
    assign rx_data = data_r;
    assign rx_valid = valid_r;
    assign soft_reset = srst_r;
    assign prog_addr = prog_r;
    chk_never_drive: assert property (@(posedge clock) disable iff (!rst_n)
        !sda_oe && !scl_oe)
        else $error("slave drives a line");
    chk_start_resets: assert property (@(posedge clock) disable iff (!rst_n)
        lines.start_seen |=> state_r == UFTL_ADDR && bit_cnt_r == 4'h0)
        else $error("start did not reset bus logic");
    chk_busy_start: assert property (@(posedge clock) disable iff (!rst_n)
        lines.start_seen |=> bus_busy)
        else $error("bus not busy after start");
    chk_stop_frees: assert property (@(posedge clock) disable iff (!rst_n)
        lines.stop_seen && !lines.start_seen |=> !bus_busy && !selected)
        else $error("stop did not release");
    chk_msb_first: assert property (@(posedge clock) disable iff (!rst_n)
        rx_valid |-> rx_data[0] == $past(lines.data_bit))
        else $error("byte order wrong");
    chk_gc_reset: assert property (@(posedge clock) disable iff (!rst_n)
        soft_reset |-> $past(state_r) == UFTL_GCALL
            && $past(byte_full) == GC_RESET_LOAD)
        else $error("soft reset without its code");
    chk_start_byte: assert property (@(posedge clock) disable iff (!rst_n)
        byte_done && state_r == UFTL_ADDR && byte_full[0] |=> !selected)
        else $error("read address selected device");
    chk_odd_gc: assert property (@(posedge clock) disable iff (!rst_n)
        gc_hit && byte_full[0] |=> $stable(prog_addr) && !soft_reset)
        else $error("odd general call code acted on");
    chk_bit_count: assert property (@(posedge clock) disable iff (!rst_n)
        bit_cnt_r <= BIT_NINTH)
        else $error("bit count overran");
endmodule
`default_nettype wire

/* pkg/uftl_line_if.sv */
// synchronised bus line view shared between front end and receiver
`timescale 1ns/1ps
`default_nettype none
interface uftl_line_if;
    logic clk_rise;
    logic data_bit;
    logic start_seen;
    logic stop_seen;
    modport front (output clk_rise, output data_bit, output start_seen,
        output stop_seen);
    modport rx (input clk_rise, input data_bit, input start_seen,
        input stop_seen);
endinterface
`default_nettype wire

/* pkg/uftl_pkg.sv */
// constants and types for the one-way two-wire slave receiver
// Function
// - bus busy from any start until stop; restart keeps it busy.
// - sampling receiver samples data at least twice per bus clock period.
// - bytes travel most significant bit first.
// - slave never holds the clock line low.
// - slave never drives the data line, not even on the ninth clock.
// - first byte is seven-bit address plus direction; read only for start byte.
// - any start resets bus logic and expects an address next.
// - start directly followed by stop is tolerated harmlessly.
// - ten-bit first byte is prefix plus two msbs and direction; second low bits.
// - ten-bit prefix and zero direction compared, then full second byte.
// - ten-bit selection lasts until stop or restart with another address; code drops selection at any restart.
// - ten-bit only write; prefix patterns with upper bit set are reserved.
// - decode honours general call, start byte, reserved and ten-bit groups.
// - start byte is never answered and may precede a ten-bit address.
// - general call received as data; unprocessable bytes silently ignored.
// - general call then 06h resets device and loads programmable address.
// - general call then 04h loads programmable address without reset.
// - 00h and other codes ignored; odd second byte ignored entirely.
// - start is data falling with clock high; stop is data rising.
package uftl_pkg;
    localparam int BYTE_BITS = 8;
    localparam logic [3:0] BIT_LAST = 4'h7;
    localparam logic [3:0] BIT_NINTH = 4'h8;
    localparam logic [6:0] GCALL_ADDR = 7'h00;
    localparam logic [4:0] TEN_PREFIX = 5'h1e;
    localparam logic [3:0] RSV_LOW_HI = 4'h0;
    localparam logic [3:0] RSV_HIGH_HI = 4'hf;
    localparam logic [7:0] GC_RESET_LOAD = 8'h06;
    localparam logic [7:0] GC_LOAD = 8'h04;
    localparam int SYNC_STAGES = 2;
    typedef enum {
        UFTL_IDLE,
        UFTL_ADDR,
        UFTL_ADDR2,
        UFTL_DATA,
        UFTL_GCALL,
        UFTL_IGNORE
    } uftl_state_t;
    typedef enum {
        UFTL_EV_NONE,
        UFTL_EV_START,
        UFTL_EV_STOP
    } uftl_event_t;
endpackage

/* test/test_uftl_slave.sv */
// self-checking bench for the one-way two-wire slave receiver
`timescale 1ns/1ps
`default_nettype none
module test_uftl_slave;
    import uftl_pkg::*;
    localparam logic [6:0] FIX = 7'h50;
    localparam logic [6:0] MASK = 7'h03;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic scl, sda, scl_oe, sda_oe, bus_busy, selected, rx_valid, soft_reset;
    logic [6:0] pins = 7'h00;
    logic [6:0] prog_addr;
    logic [6:0] own = FIX;
    logic [7:0] rx_data;
    logic sel10, v10;
    logic [7:0] d10;
    int n_ten = 0;
    logic [7:0] exp_q[$];
    int err_total = 0;
    int n_checks = 0;
    int cyc = 0;
    int n_sr = 0;
    integer seed = 32'h0463eefa;
    always #25 clock = ~clock;
    uftl_mm uftl_mm_i (.clock(clock), .scl(scl), .sda(sda));
    uftl_slave #(.OWN_ADDR7_FIXED(FIX), .PROG_MASK(MASK)) uftl_slave_i (
        .clock(clock), .rst_n(rst_n), .scl_pin(scl), .sda_pin(sda),
        .prog_addr_pins(pins), .scl_oe(scl_oe), .sda_oe(sda_oe),
        .bus_busy(bus_busy), .selected(selected), .rx_data(rx_data),
        .rx_valid(rx_valid), .soft_reset(soft_reset), .prog_addr(prog_addr));
    // second receiver on the same lines, ten-bit address 2a5
    uftl_slave #(.OWN_ADDR10(10'h2a5), .USE_TEN_BIT(1'b1)) uftl_slave_ten_i (
        .clock(clock), .rst_n(rst_n), .scl_pin(scl), .sda_pin(sda),
        .prog_addr_pins(pins), .scl_oe(), .sda_oe(), .bus_busy(),
        .selected(sel10), .rx_data(d10), .rx_valid(v10), .soft_reset(),
        .prog_addr());
    task automatic check(input logic [7:0] seen, input logic [7:0] want,
        input string what);
        n_checks++;
        if (seen !== want) begin
            err_total++;
            $display("unexpected at %0t: %s %h not %h", $time, what, seen,
                want);
        end
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // watcher: every rx_valid strobe takes the oldest expected byte
    always @(negedge clock) begin
        cyc++;
        if (cyc > 20000) begin
            err_total++;
            close_out();
        end
        if (rst_n && soft_reset === 1'b1) n_sr++;
        if (rst_n) check(8'({scl_oe, sda_oe}), 8'h00, "drive");
        if (rst_n && v10 === 1'b1) begin
            n_ten++;
            check(d10, 8'h3c, "ten data");
        end
        if (rst_n && rx_valid === 1'b1) begin
            if (exp_q.size() == 0) check(8'h01, 8'h00, "stray");
            else check(rx_data, exp_q.pop_front(), "data");
        end
    end
    // start, address, n random bytes; no stop
    task automatic xfer(input logic [7:0] a, input int n, input logic hit);
        logic [7:0] d;
        uftl_mm_i.start_c();
        check(8'(bus_busy), 8'h01, "busy");
        uftl_mm_i.send(a);
        check(8'(selected), 8'(hit), "select");
        for (int i = 0; i < n; i++) begin
            d = 8'($random(seed));
            if (hit) exp_q.push_back(d);
            uftl_mm_i.send(d);
        end
    endtask
    task automatic fin();
        uftl_mm_i.stop_c();
        repeat (3) @(negedge clock);
        check(8'({bus_busy, selected}), 8'h00, "after stop");
    endtask
    task automatic gcall(input logic [7:0] code);
        uftl_mm_i.start_c();
        uftl_mm_i.send(8'h00);
        uftl_mm_i.send(code);
        uftl_mm_i.send(8'($random(seed)));
        fin();
    endtask
    initial begin
        repeat (5) @(negedge clock);
        rst_n = 1'b1;
        repeat (4) @(negedge clock);
        xfer({own, 1'b0}, 3, 1'b1);
        xfer({own ^ 7'h04, 1'b0}, 1, 1'b0);
        xfer({own, 1'b1}, 1, 1'b0);
        fin();
        // reserved groups back to back through restarts
        for (int g = 1; g < 16; g++) begin
            xfer({g[3] ? 4'hf : 4'h0, g[2:0], 1'($random(seed))}, 1,
                1'b0);
        end
        // restart in mid-byte, then a fresh address
        xfer({own, 1'b0}, 0, 1'b1);
        for (int i = 0; i < 4; i++) uftl_mm_i.bit_s(1'($random(seed)));
        xfer({own, 1'b0}, 1, 1'b1);
        fin();
        uftl_mm_i.start_c();
        fin();
        xfer(8'h01, 0, 1'b0);
        xfer(8'hf4, 0, 1'b0);
        uftl_mm_i.send(8'ha5);
        check(8'(sel10), 8'h01, "ten select");
        uftl_mm_i.send(8'h3c);
        xfer({own, 1'b0}, 2, 1'b1);
        check(8'(sel10), 8'h00, "ten drop");
        check(8'(n_ten), 8'h01, "ten strobe");
        fin();
        pins = 7'($random(seed));
        gcall(8'h04);
        check(8'(prog_addr & MASK), 8'(pins & MASK), "load");
        check(8'(n_sr), 8'h00, "no reset");
        own = (FIX & ~MASK) | (pins & MASK);
        xfer({own, 1'b0}, 1, 1'b1);
        fin();
        pins = ~pins;
        gcall(8'h05);
        gcall(8'h00);
        gcall(8'h02);
        check(8'(prog_addr & MASK), 8'(own & MASK), "ignored");
        gcall(8'h06);
        check(8'(n_sr), 8'h01, "reset pulse");
        check(8'(prog_addr & MASK), 8'(pins & MASK), "reload");
        own = (FIX & ~MASK) | (pins & MASK);
        xfer({own, 1'b0}, 2, 1'b1);
        fin();
        check(8'(exp_q.size()), 8'h00, "missing");
        close_out();
    end
endmodule
`default_nettype wire

/* test/uftl_mm.sv */
// bus master model driving the one-way clock and data lines
`timescale 1ns/1ps
`default_nettype none
module uftl_mm (
    input wire logic clock, // system clock, paces the link
    output logic scl, // bus clock line, idles high
    output logic sda // bus data line, idles high
);
    initial begin
        scl = 1'b1;
        sda = 1'b1;
    end
    // set both lines after a falling edge, then hold n cycles
    task automatic step(input logic c, input logic d, input int n);
        scl = c;
        sda = d;
        repeat (n) @(negedge clock);
    endtask
    // data moves only while clock low, one pulse per bit
    task automatic bit_s(input logic b);
        step(1'b0, b, 2);
        step(1'b1, b, 4);
        step(1'b0, b, 2);
    endtask
    // start or restart: data falls while clock high
    task automatic start_c();
        step(1'b0, sda, 2);
        step(1'b0, 1'b1, 2);
        step(1'b1, 1'b1, 4);
        step(1'b1, 1'b0, 4);
        step(1'b0, 1'b0, 2);
    endtask
    // stop: data rises while clock high
    task automatic stop_c();
        step(1'b0, 1'b0, 2);
        step(1'b1, 1'b0, 4);
        step(1'b1, 1'b1, 4);
    endtask
    // eight bits msb first, then ninth clock with data high
    task automatic send(input logic [7:0] v);
        for (int i = 7; i >= 0; i--) begin
            bit_s(v[i]);
        end
        bit_s(1'b1);
    endtask
endmodule
`default_nettype wire
